// ### rtl/tid_top.sv
// tap instruction decoder with boundary scan, identification and bypass paths
`default_nettype none
module tid_top
   import tid_pkg::*;
#(
   parameter int              BSR_W   = BSR_W_D,
   parameter int              OUT_W   = OUT_W_D,
   parameter logic [ID_W-1:0] ID_CODE = ID_DEFAULT
) (
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   input  wire logic             tck_i,
   input  wire logic             tms_i,
   input  wire logic             tdi_i,
   output logic                  tdo_o,
   output logic                  tdo_oe_o,
   input  wire logic [BSR_W-1:0] pad_ring_i,
   input  wire logic [OUT_W-1:0] mem_dout_i,
   input  wire logic [OUT_W-1:0] mem_oe_i,
   output logic      [OUT_W-1:0] pad_dout_o,
   output logic      [OUT_W-1:0] pad_oe_o
);
   // ---------------- test clock domain ----------------
   logic             tck_rst_q1;
   logic             tck_rst_q2;
   logic [BSR_W-1:0] ring_s1_q;
   logic [BSR_W-1:0] ring_s2_q;
   tid_ir_type       ir_sh_q;
   tid_ir_type       ir_q;
   tid_path_type     path;
   logic             bypass_q;
   logic [ID_W-1:0]  id_sh_q;
   logic [BSR_W-1:0] bsr_q;
   logic [OUT_W-1:0] upd_q;
   logic             upd_tgl_q;
   logic             ext_mode_q;
   logic             hiz_mode_q;

   tid_tap_if tap ();

   // release of reset is retimed to the test clock; assertion stays asynchronous
   always_ff @(posedge tck_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tck_rst_q1 <= 1'b0;
         tck_rst_q2 <= 1'b0;
      end else begin
         tck_rst_q1 <= 1'b1;
         tck_rst_q2 <= tck_rst_q1;
      end
   end

   tid_tap_seq u_seq (
      .tck_i       (tck_i),
      .tck_rst_n_i (tck_rst_q2),
      .tms_i       (tms_i),
      .tap         (tap.seq)
   );

   // pad ring is not timed to the test clock, so it is resynchronised first;
   // values in transition at capture still give unrepeatable results
   always_ff @(posedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         ring_s1_q <= '0;
         ring_s2_q <= '0;
      end else begin
         ring_s1_q <= pad_ring_i;
         ring_s2_q <= ring_s1_q;
      end
   end

   assign path = tid_path(ir_q);

   // instruction shift register
   always_ff @(posedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         ir_sh_q <= IR_CAPT;
      end else if (tap.cap_ir) begin
         ir_sh_q <= IR_CAPT;
      end else if (tap.sh_ir) begin
         ir_sh_q <= {tdi_i, ir_sh_q[2:1]};
      end
   end

   // active instruction and its mode levels change on the falling edge
   always_ff @(negedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         ir_q       <= IR_IDCODE;
         ext_mode_q <= 1'b0;
         hiz_mode_q <= 1'b0;
      end else if (tap.tlr) begin
         ir_q       <= IR_IDCODE;
         ext_mode_q <= 1'b0;
         hiz_mode_q <= 1'b0;
      end else if (tap.upd_ir) begin
         ir_q       <= ir_sh_q;
         ext_mode_q <= (ir_sh_q == IR_EXTEST);
         hiz_mode_q <= (ir_sh_q == IR_SAMPLE_Z);
      end
   end

   // bypass stage, also chosen for reserved and vendor codes
   always_ff @(posedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         bypass_q <= 1'b0;
      end else if (path == PATH_BYP) begin
         if (tap.cap_dr) begin
            bypass_q <= 1'b0;
         end else if (tap.sh_dr) begin
            bypass_q <= tdi_i;
         end
      end
   end

   // identification register, shifted toward bit 0
   always_ff @(posedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         id_sh_q <= '0;
      end else if (path == PATH_ID) begin
         if (tap.cap_dr) begin
            id_sh_q <= ID_CODE;
         end else if (tap.sh_dr) begin
            id_sh_q <= {tdi_i, id_sh_q[ID_W-1:1]};
         end
      end
   end

   // boundary scan register; all three scan codes capture the pad ring
   always_ff @(posedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         bsr_q <= '0;
      end else if (path == PATH_BSR) begin
         if (tap.cap_dr) begin
            bsr_q <= ring_s2_q;
         end else if (tap.sh_dr) begin
            bsr_q <= {tdi_i, bsr_q[BSR_W-1:1]};
         end
      end
   end

   // output cells latch at update-dr; the toggle tells the core a new word stands
   always_ff @(negedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         upd_q     <= '0;
         upd_tgl_q <= 1'b0;
      end else if (tap.upd_dr && (path == PATH_BSR)) begin
         upd_q     <= bsr_q[OUT_W-1:0];
         upd_tgl_q <= ~upd_tgl_q;
      end
   end

   // serial output changes on the falling edge, driven only while shifting
   always_ff @(negedge tck_i or negedge tck_rst_q2) begin
      if (!tck_rst_q2) begin
         tdo_o    <= 1'b0;
         tdo_oe_o <= 1'b0;
      end else if (tap.sh_ir) begin
         tdo_o    <= ir_sh_q[0];
         tdo_oe_o <= 1'b1;
      end else if (tap.sh_dr) begin
         unique case (path)
            PATH_BSR: tdo_o <= bsr_q[0];
            PATH_ID:  tdo_o <= id_sh_q[0];
            default:  tdo_o <= bypass_q;
         endcase
         tdo_oe_o <= 1'b1;
      end else begin
         tdo_oe_o <= 1'b0;
      end
   end

   // ---------------- memory clock domain ----------------
   logic             core_rst_q1;
   logic             core_rst_q2;
   logic             ext_s1_q;
   logic             ext_s2_q;
   logic             hiz_s1_q;
   logic             hiz_s2_q;
   logic             tgl_s1_q;
   logic             tgl_s2_q;
   logic             tgl_seen_q;
   logic [OUT_W-1:0] upd_core_q;

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         core_rst_q1 <= 1'b0;
         core_rst_q2 <= 1'b0;
      end else begin
         core_rst_q1 <= 1'b1;
         core_rst_q2 <= core_rst_q1;
      end
   end

   // mode levels cross by two flops each
   always_ff @(posedge core_clk_i or negedge core_rst_q2) begin
      if (!core_rst_q2) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         hiz_s1_q <= 1'b0;
         hiz_s2_q <= 1'b0;
      end else begin
         ext_s1_q <= ext_mode_q;
         ext_s2_q <= ext_s1_q;
         hiz_s1_q <= hiz_mode_q;
         hiz_s2_q <= hiz_s1_q;
      end
   end

   // the update word is held stable in the test domain until the next update-dr,
   // so it is sampled only after its toggle has been synchronised
   always_ff @(posedge core_clk_i or negedge core_rst_q2) begin
      if (!core_rst_q2) begin
         tgl_s1_q   <= 1'b0;
         tgl_s2_q   <= 1'b0;
         tgl_seen_q <= 1'b0;
         upd_core_q <= '0;
      end else begin
         tgl_s1_q   <= upd_tgl_q;
         tgl_s2_q   <= tgl_s1_q;
         tgl_seen_q <= tgl_s2_q;
         if (tgl_s2_q != tgl_seen_q) begin
            upd_core_q <= upd_q;
         end
      end
   end

   // output driver control: float wins over external test, which wins over function
   always_ff @(posedge core_clk_i or negedge core_rst_q2) begin
      if (!core_rst_q2) begin
         pad_dout_o <= '0;
         pad_oe_o   <= '0;
      end else if (hiz_s2_q) begin
         pad_dout_o <= mem_dout_i;
         pad_oe_o   <= '0;
      end else if (ext_s2_q) begin
         pad_dout_o <= upd_core_q;
         pad_oe_o   <= '1;
      end else begin
         pad_dout_o <= mem_dout_i;
         pad_oe_o   <= mem_oe_i;
      end
   end

   // ---------------- checks ----------------
   a_tlr_load_idcode: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.tlr |=> (ir_q == IR_IDCODE) && (path == PATH_ID))
      else $error("test-logic-reset did not select identification");
   a_capture_ir_pattern: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.cap_ir |=> (ir_sh_q[1:0] == IR_CAPT[1:0]))
      else $error("capture-ir pattern wrong");
   // the load happens on the falling edge, inside the state sampled at this rising edge
   a_ir_update_only: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      $changed(ir_q) |-> tap.upd_ir || tap.tlr)
      else $error("instruction changed outside update-ir");
   a_ir_takes_shift: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.upd_ir |=> (ir_q == $past(ir_sh_q)))
      else $error("update-ir did not load shifted code");
   a_id_capture_value: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.cap_dr && (ir_q == IR_IDCODE) |=> (id_sh_q == ID_CODE))
      else $error("identification not loaded at capture-dr");
   a_id_lsb_first: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.sh_dr && (path == PATH_ID) |-> tdo_oe_o && (tdo_o == id_sh_q[0]))
      else $error("identification not shifted lsb first");
   a_bsr_serial_path: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.sh_dr && ((ir_q == IR_EXTEST) || (ir_q == IR_SAMPLE_Z) || (ir_q == IR_SAMPLE))
      |-> (tdo_o == bsr_q[0]))
      else $error("boundary scan register not in serial path");
   a_bsr_capture_ring: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.cap_dr && (ir_q == IR_SAMPLE) |=> (bsr_q == $past(ring_s2_q)))
      else $error("pad ring not captured");
   a_bypass_aliases: assert property (
      @(posedge tck_i) disable iff (!tck_rst_q2)
      tap.sh_dr && ((ir_q == IR_RSVD_A) || (ir_q == IR_RSVD_B) || (ir_q == IR_VENDOR)
      || (ir_q == IR_BYPASS)) |-> (tdo_o == bypass_q))
      else $error("bypass stage not in serial path");
   a_hiz_force_off: assert property (
      @(posedge core_clk_i) disable iff (!core_rst_q2)
      hiz_s2_q |=> (pad_oe_o == '0))
      else $error("memory outputs not floated");
   a_extest_drive_cells: assert property (
      @(posedge core_clk_i) disable iff (!core_rst_q2)
      ext_s2_q && !hiz_s2_q |=> (pad_oe_o == '1) && (pad_dout_o == $past(upd_core_q)))
      else $error("outputs not driven from boundary cells");

   c_id_shift: cover property (
      @(posedge tck_i) disable iff (!tck_rst_q2) tap.sh_dr && (path == PATH_ID));
   c_ir_update: cover property (
      @(posedge tck_i) disable iff (!tck_rst_q2) tap.upd_ir && (ir_sh_q == IR_EXTEST));
   c_extest_drive: cover property (
      @(posedge core_clk_i) disable iff (!core_rst_q2) ext_s2_q && (upd_core_q != '0));
   c_hiz_active: cover property (
      @(posedge core_clk_i) disable iff (!core_rst_q2) hiz_s2_q);
endmodule : tid_top
`default_nettype wire

// ### include/tid_pkg.sv
// shared constants, types and decode functions of the tap instruction decoder
`default_nettype none
package tid_pkg;
   localparam int ID_W     = 32;
   localparam int BSR_W_D  = 16;
   localparam int OUT_W_D  = 8;

   typedef logic [2:0] tid_ir_type;
   localparam tid_ir_type IR_EXTEST   = 3'h0;
   localparam tid_ir_type IR_IDCODE   = 3'h1;
   localparam tid_ir_type IR_SAMPLE_Z = 3'h2;
   localparam tid_ir_type IR_RSVD_A   = 3'h3;
   localparam tid_ir_type IR_SAMPLE   = 3'h4;
   localparam tid_ir_type IR_VENDOR   = 3'h5;
   localparam tid_ir_type IR_RSVD_B   = 3'h6;
   localparam tid_ir_type IR_BYPASS   = 3'h7;
   // capture pattern: low two bits 01, top bit our pick
   localparam tid_ir_type IR_CAPT     = 3'h1;

   // identification value is arbitrary; bit 0 set as the scan standard expects
   localparam logic [ID_W-1:0] ID_DEFAULT = 32'h1A5B_0C37;

   typedef enum logic [3:0] {
      TS_TLR    = 4'h0,
      TS_RTI    = 4'h1,
      TS_SEL_DR = 4'h3,
      TS_CAP_DR = 4'h2,
      TS_SH_DR  = 4'h6,
      TS_EX1_DR = 4'h7,
      TS_PAU_DR = 4'h5,
      TS_EX2_DR = 4'h4,
      TS_UPD_DR = 4'hC,
      TS_SEL_IR = 4'hD,
      TS_CAP_IR = 4'hF,
      TS_SH_IR  = 4'hE,
      TS_EX1_IR = 4'hA,
      TS_PAU_IR = 4'hB,
      TS_EX2_IR = 4'h9,
      TS_UPD_IR = 4'h8
   } tid_state_type;

   typedef enum logic [1:0] {
      PATH_BSR = 2'h0,
      PATH_ID  = 2'h1,
      PATH_BYP = 2'h2
   } tid_path_type;

   // code bits read msb first as printed; reserved and vendor codes fall to bypass
   function automatic tid_path_type tid_path(input tid_ir_type code);
      unique case (code)
         IR_EXTEST, IR_SAMPLE_Z, IR_SAMPLE: tid_path = PATH_BSR;
         IR_IDCODE:                         tid_path = PATH_ID;
         default:                           tid_path = PATH_BYP;
      endcase
   endfunction : tid_path
endpackage : tid_pkg
`default_nettype wire

// ### include/tid_tap_if.sv
// state strobes passed from the tap sequencer to the decoder
`default_nettype none
interface tid_tap_if;
   import tid_pkg::*;
   tid_state_type state;
   logic          tlr;
   logic          cap_ir;
   logic          sh_ir;
   logic          upd_ir;
   logic          cap_dr;
   logic          sh_dr;
   logic          upd_dr;
   modport seq (output state, tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr);
   modport dec (input  state, tlr, cap_ir, sh_ir, upd_ir, cap_dr, sh_dr, upd_dr);
endinterface : tid_tap_if
`default_nettype wire

// ### rtl/tid_tap_seq.sv
// sixteen-state tap sequencer clocked by the test clock
`default_nettype none
module tid_tap_seq
   import tid_pkg::*;
(
   input  wire logic tck_i,
   input  wire logic tck_rst_n_i,
   input  wire logic tms_i,
   tid_tap_if.seq    tap
);
   tid_state_type state_q;
   tid_state_type state_d;

   always_comb begin
      unique case (state_q)
         TS_TLR:    state_d = tms_i ? TS_TLR    : TS_RTI;
         TS_RTI:    state_d = tms_i ? TS_SEL_DR : TS_RTI;
         TS_SEL_DR: state_d = tms_i ? TS_SEL_IR : TS_CAP_DR;
         TS_CAP_DR: state_d = tms_i ? TS_EX1_DR : TS_SH_DR;
         TS_SH_DR:  state_d = tms_i ? TS_EX1_DR : TS_SH_DR;
         TS_EX1_DR: state_d = tms_i ? TS_UPD_DR : TS_PAU_DR;
         TS_PAU_DR: state_d = tms_i ? TS_EX2_DR : TS_PAU_DR;
         TS_EX2_DR: state_d = tms_i ? TS_UPD_DR : TS_SH_DR;
         TS_UPD_DR: state_d = tms_i ? TS_SEL_DR : TS_RTI;
         TS_SEL_IR: state_d = tms_i ? TS_TLR    : TS_CAP_IR;
         TS_CAP_IR: state_d = tms_i ? TS_EX1_IR : TS_SH_IR;
         TS_SH_IR:  state_d = tms_i ? TS_EX1_IR : TS_SH_IR;
         TS_EX1_IR: state_d = tms_i ? TS_UPD_IR : TS_PAU_IR;
         TS_PAU_IR: state_d = tms_i ? TS_EX2_IR : TS_PAU_IR;
         TS_EX2_IR: state_d = tms_i ? TS_UPD_IR : TS_SH_IR;
         TS_UPD_IR: state_d = tms_i ? TS_SEL_DR : TS_RTI;
      endcase
   end

   always_ff @(posedge tck_i or negedge tck_rst_n_i) begin
      if (!tck_rst_n_i) begin
         state_q <= TS_TLR;
      end else begin
         state_q <= state_d;
      end
   end

   assign tap.state  = state_q;
   assign tap.tlr    = (state_q == TS_TLR);
   assign tap.cap_ir = (state_q == TS_CAP_IR);
   assign tap.sh_ir  = (state_q == TS_SH_IR);
   assign tap.upd_ir = (state_q == TS_UPD_IR);
   assign tap.cap_dr = (state_q == TS_CAP_DR);
   assign tap.sh_dr  = (state_q == TS_SH_DR);
   assign tap.upd_dr = (state_q == TS_UPD_DR);

   a_tms_reset_walk: assert property (
      @(posedge tck_i) disable iff (!tck_rst_n_i)
      tms_i [*5] |=> (state_q == TS_TLR))
      else $error("five tms highs did not reach test-logic-reset");
   a_ir_entry_path: assert property (
      @(posedge tck_i) disable iff (!tck_rst_n_i)
      (state_q == TS_SEL_IR) && !tms_i |=> (state_q == TS_CAP_IR) ##1 (state_q != TS_TLR))
      else $error("select-ir did not lead to capture-ir");
endmodule : tid_tap_seq
`default_nettype wire

// ### tb/tid_jtag_ctl.sv
// board-side test controller model; the test clock runs only inside frames
`default_nettype none
module tid_jtag_ctl (
   output logic      tck_o,
   output logic      tms_o,
   output logic      tdi_o,
   input  wire logic tdo_i
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      tck_o = 1'b0;
      tms_o = 1'b1;
      tdi_o = 1'b0;
   end

   // one test clock period of 6 ns; tdo is taken at the rising edge
   task automatic step(input logic m, input logic d, output logic q);
      tms_o = m;
      tdi_o = d;
      #3;
      tck_o = 1'b1;
      q = tdo_i;
      #3;
      tck_o = 1'b0;
   endtask : step

   // five highs reach test-logic-reset from any state, then park in idle
   task automatic reset_tap();
      logic q;
      repeat (5) step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
   endtask : reset_tap

   // from idle into shift, n bits lsb first, stops in exit1 so the bench can look
   task automatic scan(input logic is_ir, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, ~tdi_o, q);
      if (is_ir) begin
         step(1'b1, ~tdi_o, q);
      end
      step(1'b0, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
   endtask : scan

   // exit1 to update then back to idle, where the clock stops
   task automatic finish();
      logic q;
      step(1'b1, ~tdi_o, q);
      step(1'b0, ~tdi_o, q);
   endtask : finish
endmodule : tid_jtag_ctl
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the tap instruction decoder
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import tid_pkg::*;

   logic                  core_clk;
   logic                  rst_n;
   logic                  tck;
   logic                  tms;
   logic                  tdi;
   logic                  tdo;
   logic                  tdo_oe;
   logic [BSR_W_D-1:0]    pad_ring;
   logic [OUT_W_D-1:0]    mem_dout;
   logic [OUT_W_D-1:0]    mem_oe;
   logic [OUT_W_D-1:0]    pad_dout;
   logic [OUT_W_D-1:0]    pad_oe;
   logic [31:0]           rd;
   int                    error_cnt;
   int                    compares;

   tid_top tid_top_inst (
      .core_clk_i (core_clk),
      .rst_n_i    (rst_n),
      .tck_i      (tck),
      .tms_i      (tms),
      .tdi_i      (tdi),
      .tdo_o      (tdo),
      .tdo_oe_o   (tdo_oe),
      .pad_ring_i (pad_ring),
      .mem_dout_i (mem_dout),
      .mem_oe_i   (mem_oe),
      .pad_dout_o (pad_dout),
      .pad_oe_o   (pad_oe)
   );

   tid_jtag_ctl tid_jtag_ctl_inst (
      .tck_o (tck),
      .tms_o (tms),
      .tdi_o (tdi),
      .tdo_i (tdo)
   );

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   task automatic close_out();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic core_wait(input int n);
      repeat (n) @(negedge core_clk);
   endtask : core_wait

   // capture pattern comes back while the new code goes in
   task automatic load_ir(input tid_ir_type code, input logic upd);
      tid_jtag_ctl_inst.scan(1'b1, 3, {29'h0, code}, rd);
      chk("ir capture", 32'h1, rd);
      if (upd) begin
         tid_jtag_ctl_inst.finish();
      end
   endtask : load_ir

   task automatic dr(input int n, input logic [31:0] din);
      tid_jtag_ctl_inst.scan(1'b0, n, din, rd);
      tid_jtag_ctl_inst.finish();
   endtask : dr

   task automatic t_reset();
      rst_n = 1'b0;
      tid_jtag_ctl_inst.reset_tap();
      core_wait(12);
      chk("oe in reset", 32'h0, {31'h0, tdo_oe});
      chk("pad oe in reset", 32'h0, {24'h0, pad_oe});
      rst_n = 1'b1;
      tid_jtag_ctl_inst.reset_tap();
      core_wait(5);
      chk("pad dout func", {24'h0, mem_dout}, {24'h0, pad_dout});
      chk("pad oe func", {24'h0, mem_oe}, {24'h0, pad_oe});
      dr(32, 32'h0);
      chk("id after reset", ID_DEFAULT, rd);
   endtask : t_reset

   task automatic t_idcode();
      load_ir(IR_IDCODE, 1'b1);
      dr(32, 32'hFFFF_FFFF);
      chk("id read", ID_DEFAULT, rd);
   endtask : t_idcode

   // one stage, captured as zero, delays tdi by one bit; the reserved codes are
   // shifted in only here, to prove they alias bypass, never in normal traffic
   task automatic t_bypass();
      tid_ir_type codes [4] = '{IR_RSVD_A, IR_VENDOR, IR_RSVD_B, IR_BYPASS};
      foreach (codes[i]) begin
         load_ir(codes[i], 1'b1);
         dr(8, 32'hA5);
         chk("bypass path", 32'h4A, rd);
      end
   endtask : t_bypass

   task automatic t_sample();
      pad_ring = 16'h1234;
      load_ir(IR_SAMPLE, 1'b1);
      dr(16, 32'h96A5);
      chk("sample capture", 32'h1234, rd);
      core_wait(5);
      chk("sample keeps pads", {24'h0, mem_oe}, {24'h0, pad_oe});
   endtask : t_sample

   task automatic t_extest();
      pad_ring = 16'h4321;
      load_ir(IR_EXTEST, 1'b1);
      core_wait(5);
      chk("extest dout", 32'hA5, {24'h0, pad_dout});
      chk("extest oe", 32'hFF, {24'h0, pad_oe});
      dr(16, 32'h0F3C);
      chk("extest capture", 32'h4321, rd);
      core_wait(5);
      chk("extest update", 32'h3C, {24'h0, pad_dout});
   endtask : t_extest

   task automatic t_samplez();
      core_wait(1);
      pad_ring = 16'h0BAD;
      load_ir(IR_SAMPLE_Z, 1'b0);
      core_wait(5);
      chk("old code holds", 32'hFF, {24'h0, pad_oe});
      tid_jtag_ctl_inst.finish();
      core_wait(5);
      chk("float oe", 32'h0, {24'h0, pad_oe});
      dr(16, 32'h0);
      chk("samplez capture", 32'h0BAD, rd);
   endtask : t_samplez

   task automatic t_tlr();
      tid_jtag_ctl_inst.reset_tap();
      core_wait(5);
      chk("tlr pads func", {24'h0, mem_oe}, {24'h0, pad_oe});
      dr(32, 32'h0);
      chk("id after tlr", ID_DEFAULT, rd);
   endtask : t_tlr

   initial begin
      rst_n     = 1'b0;
      pad_ring  = 16'hBEEF;
      mem_dout  = 8'h5A;
      mem_oe    = 8'hC3;
      error_cnt = 0;
      compares  = 0;
      core_wait(1);
      t_reset();
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_samplez();
      t_tlr();
      close_out();
   end

   // the whole run needs well under 20 us
   initial begin
      #200000;
      error_cnt++;
      close_out();
   end
endmodule : tb
`default_nettype wire
